// >>> sound_ctl_pkg.sv
package sound_ctl_pkg;

    // ----------------------------------------
    // Command word layout
    // ----------------------------------------
    localparam int WORD_BITS = 23;
    localparam int VOLUME_BITS = 8;
    localparam int TONE_BITS = 5;
    localparam int PORT_COUNT = 4;

    // ----------------------------------------
    // Register map, byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_VOLUME = 8'h00;
    localparam logic [7:0] ADDR_TONE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_SHIFT = 8'h10;

    // Status field positions
    localparam int STAT_SURR_ON = 0;
    localparam int STAT_PORTS_LSB = 4;
    localparam int STAT_LATCHED = 8;
    localparam int STAT_COUNT_LSB = 16;

    // Control reset: serial link enabled
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reset values of the active settings
    localparam logic [7:0] VOLUME_RESET = 8'h00;
    localparam logic [4:0] TONE_RESET = 5'h0F;
    localparam logic [3:0] PORTS_RESET = 4'h0;

    typedef struct packed {
        logic [7:0] volume;
        logic [4:0] treble;
        logic [4:0] bass;
        logic surround_off;
        logic [3:0] ports;
    } command_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic latch;
    } serial_lines_t;

endpackage : sound_ctl_pkg

// >>> sound_serial_rx.sv
`timescale 1ns/1ps
module sound_serial_rx
    import sound_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input sound_ctl_pkg::serial_lines_t lines,
    input wire logic enable,
    output sound_ctl_pkg::command_t shift_word,
    output logic [4:0] bit_count,
    output logic latch_pulse
);
    import sound_ctl_pkg::*;

    typedef struct packed {
        serial_lines_t sync1;
        serial_lines_t sync2;
        serial_lines_t prev;
        command_t shift;
        logic [4:0] count;
        logic pulse;
    } rx_state_t;

    rx_state_t state;
    rx_state_t next_state;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_state.sync1 = lines;
        next_state.sync2 = state.sync1;
        next_state.prev = state.sync2;
        next_state.pulse = 1'b0;
        if (enable && state.sync2.clk && !state.prev.clk) begin
            // Sample on rising shift clock, MSB enters first
            next_state.shift = {state.shift[WORD_BITS-2:0], state.sync2.data};
            if (state.count != 5'(WORD_BITS)) begin
                next_state.count = state.count + 5'h01;
            end
        end
        if (enable && state.sync2.latch && !state.prev.latch) begin
            // Latch edge hands word over, count restarts
            next_state.pulse = 1'b1;
            next_state.count = 5'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign shift_word = state.shift;
    assign bit_count = state.count;
    assign latch_pulse = state.pulse;

endmodule : sound_serial_rx

// >>> sound_ctl_top.sv
`timescale 1ns/1ps
module sound_ctl_top
    import sound_ctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic serial_latch,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] volume_code,
    output logic [4:0] treble_code,
    output logic [4:0] bass_code,
    output logic surround_on,
    output logic general_output_1,
    output logic general_output_2,
    output logic general_output_3,
    output logic general_output_4
);
    import sound_ctl_pkg::*;

    typedef struct packed {
        command_t active;
        logic surround_on;
        logic link_enable;
        logic latched_once;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Handshake readies
        logic awready;
        logic wready;
        logic arready;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    serial_lines_t lines;
    command_t shift_word;
    logic [4:0] bit_count;
    logic latch_pulse;

    assign lines = '{clk: serial_clk, data: serial_data, latch: serial_latch};

    // ----------------------------------------
    // Serial receiver
    // ----------------------------------------
    // Relies on the controller idling clock and latch lines low, so no spurious edge at start
    sound_serial_rx u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .lines(lines),
        .enable(state.link_enable),
        .shift_word(shift_word),
        .bit_count(bit_count),
        .latch_pulse(latch_pulse)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    function automatic logic [31:0] read_word(input top_state_t s, input logic [7:0] a,
                                              input command_t sw, input logic [4:0] cnt);
        logic [31:0] r;
        r = 32'h0000_0000;
        // Unmapped addresses read as zero, with an error response
        case (a)
            ADDR_VOLUME: r[7:0] = s.active.volume;
            ADDR_TONE: r = {17'h0, s.active.treble, 5'h00, s.active.bass};
            ADDR_STATUS: begin
                r[STAT_SURR_ON] = s.surround_on;
                r[STAT_PORTS_LSB +: PORT_COUNT] = s.active.ports;
                r[STAT_LATCHED] = s.latched_once;
                r[STAT_COUNT_LSB +: 5] = cnt;
            end
            ADDR_CONTROL: r[0] = s.link_enable;
            ADDR_SHIFT: r[WORD_BITS-1:0] = sw;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        return a == ADDR_VOLUME || a == ADDR_TONE || a == ADDR_STATUS ||
               a == ADDR_CONTROL || a == ADDR_SHIFT;
    endfunction : addr_ok

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        // Latch strobe moves shifted word into active settings
        if (latch_pulse) begin
            next_state.active = shift_word;
            next_state.latched_once = 1'b1;
        end
        // Surround flag is inverted: zero means effect on
        next_state.surround_on = ~next_state.active.surround_off;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !state.aw_held && !state.bvalid) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_held && !state.bvalid) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.aw_held && state.w_held) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = addr_ok(state.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // Only the link enable is writable; settings come from serial lines
            if (state.aw_addr == ADDR_CONTROL && state.w_strb[0]) begin
                next_state.link_enable = state.w_data[0];
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Read channel
        // One read in flight; arready drops while data waits
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = read_word(state, s_axi_araddr, shift_word, bit_count);
            next_state.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // Readies registered so every port leaves a flop; same timing as a direct decode
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready = !next_state.w_held && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.awready <= 1'b1;
            state.wready <= 1'b1;
            state.arready <= 1'b1;
            // Outputs off and neutral settings until first latch
            state.active.volume <= VOLUME_RESET;
            state.active.treble <= TONE_RESET;
            state.active.bass <= TONE_RESET;
            state.active.surround_off <= 1'b1;
            state.active.ports <= PORTS_RESET;
            state.link_enable <= CONTROL_RESET[0];
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;

    // Code passed raw to the attenuator DAC: FF max, AA about -10 dB
    assign volume_code = state.active.volume;
    assign treble_code = state.active.treble;
    assign bass_code = state.active.bass;
    assign surround_on = state.surround_on;
    // Bit one drives transistor on, zero off
    assign general_output_1 = state.active.ports[3];
    assign general_output_2 = state.active.ports[2];
    assign general_output_3 = state.active.ports[1];
    assign general_output_4 = state.active.ports[0];

endmodule : sound_ctl_top

// >>> sound_ctl_chk.sv
`timescale 1ns/1ps
module sound_ctl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_latch,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] volume_code,
    input wire logic surround_on,
    input wire logic general_output_1,
    input wire logic general_output_2,
    input wire logic general_output_3,
    input wire logic general_output_4
);
    // ----------------------------------------
    // Volume, surround and outputs may only move within a few cycles of a latch
    // ----------------------------------------
    logic [2:0] quiet;
    always_ff @(posedge aclk) begin
        if (!aresetn || serial_latch) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_ports: assert property ($rose(aresetn) |-> !(general_output_1 | general_output_2
        | general_output_3 | general_output_4)) else $error("outputs on after reset");
    a_reset_volume: assert property ($rose(aresetn) |-> volume_code == 8'h00 && !surround_on)
        else $error("settings wrong after reset");
    a_ports_hold: assert property (quiet == 3'h7 |-> $stable({general_output_1,
        general_output_2, general_output_3, general_output_4})) else $error("outputs moved");
    a_volume_hold: assert property (quiet == 3'h7 |-> $stable(volume_code)
        && $stable(surround_on)) else $error("volume or surround moved without latch");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
    a_wdata_block: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("write data taken while response pending");
endmodule : sound_ctl_chk

bind sound_ctl_top sound_ctl_chk chk (.aclk, .aresetn, .serial_latch, .s_axi_awready, .s_axi_wready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .volume_code, .surround_on, .general_output_1,
    .general_output_2, .general_output_3, .general_output_4);

// >>> sound_host_model.sv
`timescale 1ns/1ps
module sound_host_model (
    input wire logic aclk,
    output logic serial_clk,
    output logic serial_data,
    output logic serial_latch
);
    // ----------------------------------------
    // Controller side, hp is the half period in aclk cycles
    // ----------------------------------------
    int hp = 4;
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        serial_latch = 1'b0;
    end
    task automatic send(input logic [22:0] w, input bit do_latch);
        for (int i = 22; i >= 0; i--) begin
            serial_data <= w[i];
            repeat (hp) @(posedge aclk);
            serial_clk <= 1'b1;
            repeat (hp) @(posedge aclk);
            serial_clk <= 1'b0;
        end
        serial_data <= 1'b0;
        if (do_latch) begin
            repeat (hp) @(posedge aclk);
            serial_latch <= 1'b1;
            repeat (20) @(posedge aclk);
            serial_latch <= 1'b0;
        end
        repeat (hp) @(posedge aclk);
    endtask : send
endmodule : sound_host_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import sound_ctl_pkg::*;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
    // ----------------------------------------
    // Signals, design and controller model
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, serial_clk, serial_data, serial_latch;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, volume_code;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h5CA0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, surround_on, latch_d = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] treble_code, bass_code;
    logic general_output_1, general_output_2, general_output_3, general_output_4;
    logic [33:0] bus_q[$], exp_bus;
    command_t set_q[$], last, exp_set, settings;
    int failures = 0, checks_done = 0, cycles = 0, lcnt = 0;
    assign settings = {volume_code, treble_code, bass_code, ~surround_on, general_output_1,
        general_output_2, general_output_3, general_output_4};
    always #50 aclk = ~aclk;
    sound_ctl_top dut (.aclk, .aresetn, .serial_clk, .serial_data, .serial_latch, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .volume_code, .treble_code, .bass_code, .surround_on,
        .general_output_1, .general_output_2, .general_output_3, .general_output_4);
    sound_host_model host (.aclk, .serial_clk, .serial_data, .serial_latch);
    // Results appear on the bus handshake or six edges after a latch rise
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            test_done();
        end
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            exp_bus = bus_q.pop_front();
            if (s_axi_bvalid && s_axi_bready) `CHK({32'h0, s_axi_bresp}, exp_bus)
            else `CHK({s_axi_rdata, s_axi_rresp}, exp_bus)
        end
        latch_d <= serial_latch;
        lcnt = (serial_latch && !latch_d) ? 1 : (lcnt > 0 ? lcnt + 1 : 0);
        if (lcnt == 6) begin
            exp_set = set_q.pop_front();
            `CHK(settings, exp_set)
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({32'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({d, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read
    task automatic send(input command_t w, input bit en);
        if (en) last = w;
        set_q.push_back(last);
        host.send(w, 1'b1);
    endtask : send
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        last = {VOLUME_RESET, TONE_RESET, TONE_RESET, 1'b1, PORTS_RESET};
        `CHK(settings, last)
    endtask : do_reset
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        do_reset();
        axi_read(ADDR_CONTROL, CONTROL_RESET, RESP_OKAY);
        axi_read(ADDR_TONE, 32'h0000_3C0F, RESP_OKAY);
        axi_read(8'h14, 32'h0, RESP_SLVERR);
        axi_write(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_write(ADDR_VOLUME, 32'h0000_00FF, RESP_OKAY);
        axi_read(ADDR_VOLUME, 32'h0, RESP_OKAY);
        $display("registers done");
        send({8'hAA, 5'h0F, 5'h0F, 1'b0, 4'hA}, 1'b1);
        axi_read(ADDR_STATUS, 32'h0000_01A1, RESP_OKAY);
        axi_read(ADDR_VOLUME, 32'h0000_00AA, RESP_OKAY);
        send({8'hFF, 5'h1F, 5'h00, 1'b1, 4'h5}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            send(seed[22:0], 1'b1);
        end
        $display("serial words done");
        host.send(23'h7F_FFFF, 1'b0);
        send(23'h12_3456, 1'b1);
        axi_write(ADDR_CONTROL, 32'h0, RESP_OKAY);
        send(23'h6B_CDEF, 1'b0);
        axi_write(ADDR_CONTROL, CONTROL_RESET, RESP_OKAY);
        $display("overrun and disable done");
        do_reset();
        `CHK(bus_q.size() + set_q.size(), 0)
        test_done();
    end
endmodule : tb
